// ### dv/sdm_ctrl_model.sv
/*
  controller model driving the dram command, address and data pins.
  assumes its tasks are called by the bench between clock edges.
*/
`timescale 1ns/10ps
module sdm_ctrl_model
  import sdm_pkg::*;
(
  // clock
  input wire logic aclk,
  // command and data pins
  output sdm_pkg::sdm_cmd_t cmd,
  output logic [1:0] ba,
  output logic [11:0] addr,
  output logic [1:0] dqm,
  output logic [15:0] dq_in
);
  localparam logic [3:0] NOP = 4'h7;
  // idle pins at time zero
  initial
  begin
    cmd = NOP;
    ba = 2'h0;
    addr = 12'h000;
    dqm = 2'h0;
    dq_in = 16'h5A5A;
  end
  // one command edge, then one idle edge
  task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a);
    cmd <= c;
    ba <= b;
    addr <= a;
    @(posedge aclk);
    cmd <= NOP;
    @(posedge aclk);
  endtask
  // idle edges
  task automatic nop(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic init(input int wait_cycles);
    nop(wait_cycles);
    issue(CMD_PRE, 2'h0, 12'h400);
    issue(CMD_REF, 2'h0, 12'h000);
    issue(CMD_REF, 2'h0, 12'h000);
  endtask
  task automatic lmr(input logic [1:0] sel, input logic [11:0] word);
    issue(CMD_LMR, sel, word);
    nop(1);
  endtask
  task automatic lmr_ext(input logic [4:0] e);
    lmr(SEL_EXT, {7'h00, e});
  endtask
  // write burst, one beat per edge, then line inverted
  task automatic wr(input logic [1:0] b, input logic [8:0] col, input int n, input logic [15:0] d0, input logic stop);
    cmd <= CMD_WR;
    ba <= b;
    addr <= {3'h0, col};
    dq_in <= d0;
    @(posedge aclk);
    for (int i = 1; i < n; i++)
    begin
      cmd <= NOP;
      dq_in <= d0 + 16'(i);
      @(posedge aclk);
    end
    dq_in <= ~(d0 + 16'(n - 1));
    cmd <= stop ? CMD_BST : NOP;
    @(posedge aclk);
    cmd <= NOP;
    @(posedge aclk);
  endtask
endmodule

// ### dv/sdm_props.sv
/*
  checker for the dram device: read timing against a tracked mode word,
  and register bus views of the loaded mode words.
  assumes it is bound to sdm_device and sees only its ports.
*/
`timescale 1ns/10ps
module sdm_props
  import sdm_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus read side
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // dram pins
  input wire sdm_pkg::sdm_cmd_t cmd,
  input wire logic [1:0] ba,
  input wire logic [11:0] addr,
  input wire logic [1:0] dqm,
  input wire logic [1:0] dq_oe_n
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // decoded pins and tracked state
  wire logic [3:0] code = cmd;
  logic is_nop, rd_open, rd_shut, cl2, norm, quiet;
  sdm_mode_t mode_trk;
  sdm_ext_t ext_trk;
  logic [3:0] open_trk, shut_trk, idle_cnt;
  logic [7:0] ar_trk;
  assign is_nop = (code == 4'h7) || code[3];
  assign cl2 = (mode_trk.read_latency_field == CL_2);
  assign norm = !mode_trk.op_mode_high_bit && !mode_trk.op_mode_low_bit;
  // quiet: no burst may still be in flight
  assign quiet = (idle_cnt == 4'hF) && (dq_oe_n == 2'h3) && (dqm == 2'h0);
  assign rd_open = quiet && (code == CMD_RD) && open_trk[ba];
  assign rd_shut = quiet && (code == CMD_RD) && shut_trk[ba];
  // mode words follow loads on the pins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_trk <= MODE_RST;
      ext_trk <= EXT_RST;
    end
    else if (code == CMD_LMR && ba == SEL_MODE)
      mode_trk <= addr;
    else if (code == CMD_LMR && ba == SEL_EXT)
      ext_trk <= addr[4:0];
  end
  // banks surely open or surely shut; auto precharge leaves neither
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      open_trk <= 4'h0;
      shut_trk <= 4'hF;
    end
    else if (code == CMD_ACT)
    begin
      open_trk[ba] <= 1'b1;
      shut_trk[ba] <= 1'b0;
    end
    else if (code == CMD_PRE)
    begin
      open_trk <= addr[AP_BIT] ? 4'h0 : open_trk & ~(4'h1 << ba);
      shut_trk <= addr[AP_BIT] ? 4'hF : shut_trk | (4'h1 << ba);
    end
    else if ((code == CMD_RD || code == CMD_WR) && addr[AP_BIT])
      open_trk[ba] <= 1'b0;
  end
  // edges since the last read or write, saturating
  always_ff @(posedge aclk)
  begin
    if (!aresetn || code == CMD_RD || code == CMD_WR)
      idle_cnt <= 4'h0;
    else if (idle_cnt != 4'hF)
      idle_cnt <= idle_cnt + 4'h1;
  end
  // address of the read under way
  always_ff @(posedge aclk)
  begin
    if (s_axi_arvalid && s_axi_arready)
      ar_trk <= s_axi_araddr;
  end
  AST_RD_NOT_EARLY: assert property (rd_open |=> dq_oe_n == 2'h3)
    else $error("read drove data one edge after the command");
  AST_CL2_START: assert property ((rd_open && norm && cl2) ##1 is_nop |=> dq_oe_n == 2'h0)
    else $error("latency two read not driving after the next edge");
  AST_CL3_START: assert property ((rd_open && norm && !cl2) ##1 (is_nop && dqm == 2'h0) ##1 is_nop |-> dq_oe_n == 2'h3 ##1 dq_oe_n == 2'h0)
    else $error("latency three read drive edge wrong");
  AST_BL2_END: assert property ((rd_open && norm && cl2 && mode_trk.burst_length_field == BL_2) ##1 is_nop [*3] |=> dq_oe_n == 2'h3)
    else $error("two beat read still driving");
  AST_TEST_MODE: assert property ((rd_open && !norm) ##1 is_nop [*3] |-> dq_oe_n == 2'h3)
    else $error("read drove data outside normal mode");
  AST_SHUT_BANK: assert property (rd_shut ##1 is_nop [*3] |-> dq_oe_n == 2'h3)
    else $error("read to a closed bank drove data");
  AST_MODE_VIEW: assert property ((s_axi_rvalid && s_axi_rready && ar_trk == OFS_MODE && $stable(mode_trk)) |-> s_axi_rdata[11:0] == mode_trk)
    else $error("mode word differs from the last load");
  AST_EXT_VIEW: assert property ((s_axi_rvalid && s_axi_rready && ar_trk == OFS_EXT && $stable(ext_trk)) |-> s_axi_rdata[4:0] == ext_trk)
    else $error("extended word differs from the last load");
  // main scenarios reached
  cover property (rd_open && norm && cl2);
  cover property (rd_open && norm && !cl2);
  cover property (code == CMD_LMR && ba == SEL_EXT);
endmodule

// ### dv/tb.sv
/*
  bench for the dram device: register bus reads and writes, then
  command sequences through the controller model with expected data.
  assumes the model and checker files are compiled before this one.
*/
`timescale 1ns/10ps
module tb;
  import sdm_pkg::*;
  // clock, reset, counters
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  int bad_count = 0, check_count = 0;
  // register bus
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [3:0] wstrb = 4'hF;
  // dram pins
  sdm_cmd_t cmd;
  logic [1:0] ba, dqm, dq_oe_n;
  logic [11:0] addr;
  logic [15:0] dq_in, dq_out;
  // burst setup, expected words of bank 1
  int bl, cl;
  logic il, wbm;
  logic [15:0] exp_mem [int];
  always #50 aclk = ~aclk;
  sdm_ctrl_model ctrl_inst (.aclk(aclk), .cmd(cmd), .ba(ba), .addr(addr), .dqm(dqm), .dq_in(dq_in));
  sdm_device sdm_device_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cmd(cmd), .ba(ba), .addr(addr),
    .dqm(dqm), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n));
  // compare and count
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // one bus transfer, each channel released when taken
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] qo,
                     output logic [1:0] ro);
    int t = 0;
    logic done = 1'b0;
    if (wr)
    begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end
    else
    begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    while (!done && t < 50)
    begin
      @(posedge aclk);
      t++;
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (wr && bvalid === 1'b1)
      begin
        ro = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
      if (!wr && rvalid === 1'b1)
      begin
        ro = rresp;
        qo = rdata;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done)
      bad_count++;
    @(posedge aclk);
  endtask
  // read a register and compare data and response
  task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    bus(1'b0, a, 32'h0, q, r);
    chk("rdata", exp, q);
    chk("rresp", 32'(er), 32'(r));
  endtask
  // column of beat i from the start column
  function automatic int col_at(input int s, input int i);
    if (bl == 512)
      return (s + i) % 512;
    return (s & ~(bl - 1)) | ((il ? (s ^ i) : (s + i)) & (bl - 1));
  endfunction
  // precharge all, load mode, reopen bank 1
  task automatic set_mode(input logic [11:0] m);
    ctrl_inst.issue(CMD_PRE, 2'h0, 12'h400);
    ctrl_inst.lmr(SEL_MODE, m);
    ctrl_inst.issue(CMD_ACT, 2'h1, 12'h123);
    bl = (m[2:0] == BL_FULL) ? 512 : (1 << m[2:0]);
    il = m[3];
    cl = (m[6:4] == CL_2) ? 2 : 3;
    wbm = m[9];
  endtask
  // write burst to bank 1 and note the expected columns
  task automatic wr_b(input int col, input int n, input logic [15:0] d0);
    ctrl_inst.wr(2'h1, 9'(col), n, d0, bl == 512);
    for (int i = 0; i < (wbm ? 1 : n); i++)
      exp_mem[col_at(col, i)] = d0 + 16'(i);
    ctrl_inst.nop(16);
  endtask
  // read burst: beat i settled after edge n+cl-1+i
  task automatic rd_b(input int col, input int n);
    ctrl_inst.issue(CMD_RD, 2'h1, {3'h0, 9'(col)});
    repeat (cl - 1) @(negedge aclk);
    for (int i = 0; i < n; i++)
    begin
      chk("dq_oe_n", 32'h0, 32'(dq_oe_n));
      chk("dq_out", 32'(exp_mem[col_at(col, i)]), 32'(dq_out));
      @(negedge aclk);
    end
    @(posedge aclk);
    if (bl == 512)
      ctrl_inst.issue(CMD_BST, 2'h1, 12'h000);
    ctrl_inst.nop(16);
  endtask
  // read that must leave the data pins undriven
  task automatic rd_none(input logic [1:0] b);
    ctrl_inst.issue(CMD_RD, b, 12'h008);
    repeat (4) @(negedge aclk);
    chk("dq_oe_n idle", 32'h3, 32'(dq_oe_n));
    ctrl_inst.nop(16);
  endtask
  // watchdog
  initial
  begin
    #2000000;
    bad_count++;
    close_out();
  end
  // test sequence
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    wstrb <= 4'hE;
    bus(1'b1, OFS_CTRL, 32'h0, q, r);
    reg_chk(OFS_CTRL, 32'(CTRL_RST), RESP_OKAY);
    reg_chk(8'h40, 32'h0, RESP_DECERR);
    bus(1'b1, 8'h40, 32'h1, q, r);
    chk("bresp", 32'(RESP_DECERR), 32'(r));
    bus(1'b1, OFS_MODE, 32'hFFF, q, r);
    reg_chk(OFS_MODE, 32'h0, RESP_OKAY);
    $display("test reset done");
    ctrl_inst.init(2000);
    ctrl_inst.lmr(SEL_MODE, 12'h022);
    ctrl_inst.lmr_ext(5'h15);
    ctrl_inst.lmr(2'h1, 12'h0FF);
    reg_chk(OFS_MODE, 32'h022, RESP_OKAY);
    reg_chk(OFS_EXT, 32'h15, RESP_OKAY);
    bus(1'b0, OFS_STAT, 32'h0, q, r);
    chk("status", 32'h6C0, q & 32'h7CF);
    $display("test init done");
    set_mode(12'h022);
    bus(1'b0, OFS_STAT, 32'h0, q, r);
    chk("open banks", 32'h2, q & 32'hF);
    wr_b(5, 4, 16'h1000);
    rd_b(5, 4);
    rd_b(6, 4);
    set_mode(12'h03B);
    wr_b(11, 8, 16'h2000);
    rd_b(13, 8);
    $display("test fixed bursts done");
    set_mode(12'h221);
    wr_b(9, 2, 16'h3000);
    rd_b(8, 2);
    set_mode(12'h027);
    wr_b(510, 4, 16'h4000);
    rd_b(511, 3);
    $display("test write mode and full page done");
    rd_none(2'h2);
    set_mode(12'h0A2);
    rd_none(2'h1);
    bus(1'b0, OFS_STAT, 32'h0, q, r);
    chk("normal flag", 32'h0, q & 32'h400);
    $display("test refused reads done");
    close_out();
  end
endmodule
bind sdm_device sdm_props sdm_props_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .cmd(cmd), .ba(ba), .addr(addr), .dqm(dqm),
  .dq_oe_n(dq_oe_n));

// ### hw/sdm_burst_addr.sv
/*
  column address of one beat inside a burst.
  assumes a length code and burst type from the mode register and
  a beat index counted from zero by the caller.
*/
`timescale 1ns/10ps
module sdm_burst_addr
  import sdm_pkg::*;
(
  // burst description
  input wire logic [8:0] start,
  input wire logic [2:0] len_code,
  input wire logic itype,
  input wire logic [8:0] idx,
  // resulting column
  output logic [8:0] col
);
  logic [8:0] mask;
  wire logic full_page = (len_code == BL_FULL);
  wire logic [8:0] seq_col = start + idx;
  wire logic [8:0] low = (itype && !full_page) ? (start ^ idx) : seq_col;

  // block mask, reserved codes act as single beats
  always_comb
  begin
    case (len_code)
      BL_2: mask = 9'h001;
      BL_4: mask = 9'h003;
      BL_8: mask = 9'h007;
      BL_FULL: mask = 9'h1FF;
      default: mask = 9'h000;
    endcase
  end

  // full page wraps inside the row
  assign col = (start & ~mask) | (low & mask);
endmodule

// ### hw/sdm_device.sv
/*
  synchronous dram device: command decode, four banks of storage,
  mode and extended mode registers, read and write bursts with
  programmable latency, and an axi4-lite window for software.
  assumes command pins change with the same aclk that samples them
  and that the controller keeps the power-up and load sequence.
*/
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/10ps
module sdm_device
  import sdm_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // dram command and address pins
  input wire sdm_pkg::sdm_cmd_t cmd,
  input wire logic [1:0] ba,
  input wire logic [11:0] addr,
  input wire logic [1:0] dqm,
  // dram data pins, enable low while driving
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic [1:0] dq_oe_n
);
  logic [15:0] mem [0:MEM_WORDS-1];

  // mode state
  sdm_mode_t mode_reg;
  sdm_ext_t ext_reg;
  logic mode_loaded;
  logic ext_loaded;
  logic [1:0] ref_cnt;
  logic drive_en;

  // open rows per bank
  logic [3:0] row_open;
  logic [11:0] row_addr [0:3];

  // read burst engine
  logic rd_act;
  logic [1:0] rd_bank;
  logic [11:0] rd_row;
  logic [8:0] rd_start;
  logic [8:0] rd_idx;
  logic rd_ap;

  // write burst engine
  logic wr_act;
  logic [1:0] wr_bank;
  logic [11:0] wr_row;
  logic [8:0] wr_start;
  logic [8:0] wr_idx;
  logic wr_ap;

  // output pipeline and mask delay
  logic p1_valid;
  logic [15:0] p1_data;
  logic [1:0] dqm_q;

  // bus slave state
  logic [7:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;

  // commands decoded straight from the sampled pins
  wire logic [3:0] cmd_code = cmd;
  wire logic is_act = (cmd_code == CMD_ACT);
  wire logic is_rd = (cmd_code == CMD_RD);
  wire logic is_wr = (cmd_code == CMD_WR);
  wire logic is_pre = (cmd_code == CMD_PRE);
  wire logic is_ref = (cmd_code == CMD_REF);
  wire logic is_bst = (cmd_code == CMD_BST);
  wire logic is_lmr = (cmd_code == CMD_LMR);

  // only the normal operating mode runs bursts
  wire logic op_normal = !mode_reg.op_mode_high_bit && !mode_reg.op_mode_low_bit;
  // column commands act only on an open row
  wire logic rd_go = is_rd && row_open[ba] && op_normal;
  wire logic wr_go = is_wr && row_open[ba] && op_normal;
  // precharge hitting a bank: all banks when the flag bit is high
  wire logic pre_all = is_pre && addr[AP_BIT];
  wire logic pre_rd = is_pre && (pre_all || ba == rd_bank);
  wire logic pre_wr = is_pre && (pre_all || ba == wr_bank);

  // index of the last beat of a burst, full page counted as unbounded
  wire logic [2:0] bl = mode_reg.burst_length_field;
  wire logic bl_full = (bl == BL_FULL);
  wire logic [8:0] bl_last = (bl == BL_2) ? 9'h001 : (bl == BL_4) ? 9'h003 : (bl == BL_8) ? 9'h007 : 9'h000;
  // single writes when the write burst mode bit is set
  wire logic wr_single = mode_reg.write_burst_mode_bit || (!bl_full && bl_last == 9'h000);

  // column of the current beat of each engine
  logic [8:0] rd_col;
  logic [8:0] wr_col;

  // burst type bit set gives interleaved order, except full page which stays sequential
  sdm_burst_addr u_rd_addr (
    .start(rd_start),
    .len_code(bl),
    .itype(mode_reg.burst_type_bit),
    .idx(rd_idx),
    .col(rd_col)
  );

  sdm_burst_addr u_wr_addr (
    .start(wr_start),
    .len_code(bl),
    .itype(mode_reg.burst_type_bit),
    .idx(wr_idx),
    .col(wr_col)
  );

  // end of burst and truncation
  wire logic rd_last = rd_act && !bl_full && (rd_idx == bl_last);
  wire logic rd_stop = rd_go || wr_go || is_bst || pre_rd;
  wire logic wr_last = wr_act && !bl_full && (wr_idx == bl_last);
  wire logic wr_stop = rd_go || wr_go || is_bst || pre_wr;

  // read beat fetched from the array
  wire logic [22:0] rd_index = {rd_bank, rd_row, rd_col};
  wire logic [15:0] rd_word = mem[rd_index];

  // starting column on the low address lines
  wire logic [8:0] cmd_col = addr[8:0];
  // write beat address and enable
  wire logic wr_now = wr_go || (wr_act && !wr_stop);
  wire logic [22:0] wr_index = wr_go ? {ba, row_addr[ba], cmd_col} : {wr_bank, wr_row, wr_col};

  // latency two feeds the pins directly, else one stage later
  wire logic cl_two = (mode_reg.read_latency_field == CL_2);
  wire logic src_valid = cl_two ? rd_act : p1_valid;
  wire logic [15:0] src_data = cl_two ? rd_word : p1_data;

  // bus decode
  wire logic aw_fire = s_axi_awvalid && s_axi_awready;
  wire logic w_fire = s_axi_wvalid && s_axi_wready;
  wire logic ar_fire = s_axi_arvalid && s_axi_arready;
  wire logic wr_both = (aw_held || aw_fire) && (w_held || w_fire) && !s_axi_bvalid;
  wire logic [7:0] wa = aw_held ? aw_addr : s_axi_awaddr;
  wire logic [31:0] wd = w_held ? w_data : s_axi_wdata;
  wire logic [3:0] ws = w_held ? w_strb : s_axi_wstrb;
  wire logic wa_ok = (wa == OFS_CTRL) || (wa == OFS_MODE) || (wa == OFS_EXT) || (wa == OFS_STAT);
  wire logic ra_ok = (s_axi_araddr == OFS_CTRL) || (s_axi_araddr == OFS_MODE) ||
    (s_axi_araddr == OFS_EXT) || (s_axi_araddr == OFS_STAT);

  // status word
  logic [31:0] stat_word;
  always_comb
  begin
    stat_word = 32'h00000000;
    stat_word[ST_OPEN +: 4] = row_open;
    stat_word[ST_RD] = rd_act;
    stat_word[ST_WR] = wr_act;
    stat_word[ST_MODE_LD] = mode_loaded;
    stat_word[ST_EXT_LD] = ext_loaded;
    stat_word[ST_REF +: 2] = ref_cnt;
    stat_word[ST_NORMAL] = op_normal;
  end

  // read data select
  wire logic [31:0] rd_sel = (s_axi_araddr == OFS_CTRL) ? {31'h00000000, drive_en} :
    (s_axi_araddr == OFS_MODE) ? {20'h00000, mode_reg} :
    (s_axi_araddr == OFS_EXT) ? {27'h0000000, ext_reg} :
    (s_axi_araddr == OFS_STAT) ? stat_word : 32'h00000000;

  // mode registers and init tracking
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_reg <= MODE_RST;
      ext_reg <= EXT_RST;
      mode_loaded <= 1'b0;
      ext_loaded <= 1'b0;
      ref_cnt <= 2'h0;
    end
    // mode word written only by a load
    // word on address, select on bank lines
    else if (is_lmr && ba == SEL_MODE)
    begin
      // fields laid out by the struct
      mode_reg <= addr;
      mode_loaded <= 1'b1;
    end
    // select bits high, low pick extended register
    else if (is_lmr && ba == SEL_EXT)
    begin
      // array and temperature refresh fields kept
      ext_reg <= addr[4:0];
      ext_loaded <= 1'b1;
    end
    // refreshes counted for status only
    else if (is_ref && ref_cnt != REF_MAX)
      ref_cnt <= ref_cnt + 2'h1;
  end

  // bank open state and row capture
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      row_open <= 4'h0;
      for (int b = 0; b < 4; b++)
        row_addr[b] <= 12'h000;
    end
    else
    begin
      // bank from bank lines, row from address
      if (is_act)
      begin
        row_open[ba] <= 1'b1;
        row_addr[ba] <= addr;
      end
      // precharge closes one bank or all
      if (pre_all)
        row_open <= 4'h0;
      else if (is_pre)
        row_open[ba] <= 1'b0;
      // auto precharge at the natural end of a read or multi-beat write burst
      if (rd_last && rd_ap && !rd_stop)
        row_open[rd_bank] <= 1'b0;
      if (wr_last && wr_ap && !wr_stop)
        row_open[wr_bank] <= 1'b0;
    end
  end

  // read engine: one beat per clock from the read edge on
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_act <= 1'b0;
      rd_bank <= 2'h0;
      rd_row <= 12'h000;
      rd_start <= 9'h000;
      rd_idx <= 9'h000;
      rd_ap <= 1'b0;
    end
    else if (rd_go)
    begin
      // new read replaces any burst under way
      rd_act <= 1'b1;
      rd_bank <= ba;
      rd_row <= row_addr[ba];
      rd_start <= cmd_col;
      rd_idx <= 9'h000;
      rd_ap <= addr[AP_BIT];
    end
    // terminate, write or precharge ends the burst
    else if (rd_stop || rd_last)
      rd_act <= 1'b0;
    else if (rd_act)
      rd_idx <= rd_idx + 9'h001;
  end

  // write engine: first beat on the write edge, then one per clock
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_act <= 1'b0;
      wr_bank <= 2'h0;
      wr_row <= 12'h000;
      wr_start <= 9'h000;
      wr_idx <= 9'h000;
      wr_ap <= 1'b0;
    end
    else if (wr_go)
    begin
      // no further beats for single writes
      wr_act <= !wr_single;
      wr_bank <= ba;
      wr_row <= row_addr[ba];
      wr_start <= cmd_col;
      wr_idx <= 9'h001;
      wr_ap <= addr[AP_BIT];
    end
    else if (wr_stop || wr_last)
      wr_act <= 1'b0;
    else if (wr_act)
      wr_idx <= wr_idx + 9'h001;
  end

  // array write, each byte lane masked by its mask pin
  always_ff @(posedge aclk)
  begin
    if (wr_now && !dqm[0])
      mem[wr_index][7:0] <= dq_in[7:0];
    if (wr_now && !dqm[1])
      mem[wr_index][15:8] <= dq_in[15:8];
  end

  // latency pipeline and data pins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      p1_valid <= 1'b0;
      p1_data <= 16'h0000;
      dqm_q <= 2'h0;
      dq_out <= 16'h0000;
      dq_oe_n <= 2'h3;
    end
    else
    begin
      dqm_q <= dqm;
      // extra stage for latency three, emptied by a write
      p1_valid <= rd_act && !wr_go;
      p1_data <= rd_word;
      dq_out <= src_data;
      // drive after edge n+m-1, valid by n+m
      // a registered write puts the pins in high impedance
      if (wr_go || !drive_en || !src_valid)
        dq_oe_n <= 2'h3;
      else
        dq_oe_n <= dqm_q;
    end
  end

  // bus write channels: address and data taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end
    else
    begin
      if (aw_fire)
      begin
        aw_addr <= s_axi_awaddr;
        aw_held <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (w_fire)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_held <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      // both halves in: release holds, reopen after response
      if (wr_both)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // write response and control register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      drive_en <= CTRL_RST;
    end
    else if (wr_both)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wa_ok ? RESP_OKAY : RESP_DECERR;
      // only the control word is writable
      if (wa == OFS_CTRL && ws[0])
        drive_en <= wd[0];
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // bus read channel, answer one clock after the address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (ar_fire)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_sel;
      s_axi_rresp <= ra_ok ? RESP_OKAY : RESP_DECERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule

// ### hw/sdm_pkg.sv
/*
  shared constants and types of the synchronous dram device model:
  array geometry, command codes, mode and extended mode layouts,
  register bus offsets and reset values.
  assumes a single clock and no other package.
*/
package sdm_pkg;
  // array geometry, x16 organisation
  localparam int BANK_W = 2;
  localparam int ROW_W = 12;
  localparam int COL_W = 9;
  localparam int WORD_W = 16;
  localparam int MEM_WORDS = 4 * 4096 * 512;
  localparam int AP_BIT = 10;

  // command pins, one struct
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } sdm_cmd_t;

  // command codes {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_LMR = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_BST = 4'h6;

  // mode register word as carried on the address lines
  typedef struct packed {
    logic reserved_bit_eleven;
    logic reserved_bit_ten;
    logic write_burst_mode_bit;
    logic op_mode_high_bit;
    logic op_mode_low_bit;
    logic [2:0] read_latency_field;
    logic burst_type_bit;
    logic [2:0] burst_length_field;
  } sdm_mode_t;

  // extended mode register, upper bits are written as zero
  typedef struct packed {
    logic [1:0] temp_comp_refresh_field;
    logic [2:0] partial_array_refresh_field;
  } sdm_ext_t;

  localparam sdm_mode_t MODE_RST = 12'h000;
  localparam sdm_ext_t EXT_RST = 5'h00;

  // register select values on the bank lines
  localparam logic [1:0] SEL_MODE = 2'h0;
  localparam logic [1:0] SEL_EXT = 2'h2;

  // burst length and latency codes
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_FULL = 3'h7;
  localparam logic [2:0] CL_2 = 3'h2;

  // register bus map
  localparam int AXI_AW = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_EXT = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic CTRL_RST = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam logic [1:0] REF_MAX = 2'h2;

  // status field positions
  localparam int ST_OPEN = 0;
  localparam int ST_RD = 4;
  localparam int ST_WR = 5;
  localparam int ST_MODE_LD = 6;
  localparam int ST_EXT_LD = 7;
  localparam int ST_REF = 8;
  localparam int ST_NORMAL = 10;
endpackage
